// ==== rpes_consts.svh ====
// rpes_consts.svh: offsets, field positions, reset values and widths of the port event status block.
// assumes: included by rpes_pkg.sv and rpes_top.sv, by bare name.
`ifndef RPES_CONSTS_SVH
`define RPES_CONSTS_SVH

// register byte offsets
`define RPES_OFF_PORT_STAT 12'h000
`define RPES_OFF_CSYM_STAT 12'h004
`define RPES_OFF_GLB_STAT 12'h008
`define RPES_OFF_INT_EN 12'h00C
`define RPES_OFF_PW_EN 12'h010
`define RPES_OFF_DEG_THR 12'h014
`define RPES_OFF_OUTQ_THR 12'h018
`define RPES_OFF_INQ_THR 12'h01C
`define RPES_OFF_RDR_THR 12'h020
`define RPES_OFF_ERR_CNT 12'h024
`define RPES_OFF_OUTQ_CNT 12'h028
`define RPES_OFF_INQ_CNT 12'h02C
`define RPES_OFF_RDR_CNT 12'h030

// port status bit positions; also used in the enable registers
`define RPES_BIT_DEG 0
`define RPES_BIT_OUTQ 1
`define RPES_BIT_INQ 2
`define RPES_BIT_RDR 3
`define RPES_BIT_RST 4
`define RPES_BIT_MC 5
// bit positions in control-symbol and global status registers
`define RPES_BIT_CS_MC 0
`define RPES_BIT_CS_RST 1

`define RPES_NEV 6
`define RPES_CNT_W 16
`define RPES_RST_SYM_RUN 3'h4

// reset values
`define RPES_RST_THR 16'hFFFF
`define RPES_RST_RDR_THR 16'hFFFF
`define RPES_RST_EN 6'h00

`endif

// ==== rpes_link_model.sv ====
// rpes_link_model.sv: link side model that strobes the port events.
// assumes: called right after a pclk edge.
`timescale 1ns/1ps
`default_nettype none
module rpes_link_model (
  input wire logic pclk, // clock
  output logic err_rate_inc, // error step
  output logic outq_exceed, // outbound over
  output logic inq_exceed, // inbound over
  output logic rdr_inc, // reorder
  output logic sym_valid, // symbol strobe
  output logic sym_is_rst, // reset request
  output logic sym_is_mc // multicast
);
  logic [3:0] ev = 4'h0;
  logic busy = 1'b0;
  assign {rdr_inc, inq_exceed, outq_exceed, err_rate_inc} = ev;
  initial {sym_valid, sym_is_rst, sym_is_mc} = 3'b010;
  // qualifiers wander while no symbol is sent
  always @(posedge pclk)
    if (!busy)
      {sym_is_rst, sym_is_mc} <= ~{sym_is_rst, sym_is_mc};
  task send(input int k, input int n);
    repeat (n)
    begin
      @(posedge pclk);
      ev[k] <= 1'b1;
      @(posedge pclk);
      ev[k] <= 1'b0;
    end
  endtask : send
  task sym(input logic r, input logic m, input int n);
    busy = 1'b1;
    repeat (n)
    begin
      @(posedge pclk);
      {sym_valid, sym_is_rst, sym_is_mc} <= {1'b1, r, m};
    end
    @(posedge pclk);
    sym_valid <= 1'b0;
    busy = 1'b0;
  endtask : sym
endmodule : rpes_link_model
`default_nettype wire

// ==== rpes_pkg.sv ====
// rpes_pkg.sv: types of the port event status block.
// assumes: rpes_consts.svh is on the include path.
`include "rpes_consts.svh"

package rpes_pkg;

  typedef logic [`RPES_CNT_W-1:0] rpes_cnt_t;
  typedef logic [`RPES_NEV-1:0] rpes_ev_t;

  // apb slave phase
  typedef enum logic [1:0] {
    RPES_IDLE = 2'b01,
    RPES_ACC = 2'b10
  } rpes_apb_e;

endpackage : rpes_pkg

// ==== rpes_top.sv ====
// rpes_top.sv: event detection, status recording and notification flags of one switch port.
// assumes: apb master on pclk; event strobes from the port logic are one-cycle, synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
`include "rpes_consts.svh"

// Functional notes
// R1: raise degraded event when error rate count reaches the degraded threshold.
// R2: degraded event sets output_degraded_flag; may interrupt and port-write.
// R3: reset-request event after four consecutive reset symbols; interrupt only.
// R4: reset event sets reset_symbol_seen_flag in control-symbol and global status.
// R5: every multicast-event control symbol raises the multicast event; interrupt only.
// R6: multicast event sets multicast_symbol_seen_flag in control-symbol and global status.
// R7: count inbound queue exceedances; event when count reaches inbound threshold.
// R8: inbound event sets inbound_congestion_flag; may interrupt and port-write.
// R9: reorder event when reorder count reaches threshold; interrupt and port-write.
// R10: reorder event sets reorder_threshold_flag.
// R11: reorder threshold resets to 0xFFFF, suppressing the event; the code still raises it once the reorder count reaches 0xFFFF.
// R12: count outbound queue exceedances; event at threshold; interrupt and port-write.
// R13: no priority among events; each flagged independently.
// R14: active-low interrupt output asserted while any enabled event is recorded.
module rpes_top
  import rpes_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic err_rate_inc, // error rate counter step
  input wire logic outq_exceed, // outbound queue over threshold
  input wire logic inq_exceed, // inbound queue over threshold
  input wire logic rdr_inc, // packet reordered
  input wire logic sym_valid, // control symbol received
  input wire logic sym_is_rst, // symbol is reset request
  input wire logic sym_is_mc, // symbol is multicast event
  output logic int_n, // interrupt, low
  output logic pw_req, // port-write request, level
  output logic [5:0] event_pulse // raw event strobes
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction : hit

  // counts saturate at all ones; a hit clears the count
  function automatic rpes_cnt_t cnt_step(input rpes_cnt_t c, input logic inc, input logic clr);
    if (clr)
      cnt_step = '0;
    else if (inc && c != `RPES_RST_THR)
      cnt_step = c + 16'h0001;
    else
      cnt_step = c;
  endfunction : cnt_step

  ////////////////////////////////////////////////////////////////////////////
  rpes_apb_e ph_q, ph_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  rpes_ev_t stat_q, stat_d;
  logic [1:0] csym_q, csym_d;
  logic [1:0] glb_q, glb_d;
  rpes_ev_t int_en_q, int_en_d;
  rpes_ev_t pw_en_q, pw_en_d;
  rpes_cnt_t thr_q [4];
  rpes_cnt_t thr_d [4];
  rpes_cnt_t cnt_q [4];
  rpes_cnt_t cnt_d [4];
  logic [2:0] rst_run_q, rst_run_d;
  logic int_n_q, int_n_d;
  logic pw_q, pw_d;
  rpes_ev_t ev_q, ev_d;
  logic [3:0] cnt_inc;
  logic [3:0] cnt_hit;
  rpes_ev_t ev;
  logic wr;
  logic [31:0] wclr;
  logic mapped;

  assign wr = psel && penable && pwrite && ph_q == RPES_ACC;
  // write data doubles as the clear mask of the status registers
  assign wclr = wr ? pwdata : 32'h0000_0000;
  assign cnt_inc = {rdr_inc, inq_exceed, outq_exceed, err_rate_inc};

  ////////////////////////////////////////////////////////////////////////////
  // threshold counters: 0 error rate, 1 outbound, 2 inbound, 3 reorder
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_cnt
      always_comb
      begin
        // zero threshold never fires; a saturated count would wrap onto it
        cnt_hit[gi] = cnt_inc[gi] && thr_q[gi] != 16'h0000 && cnt_q[gi] + 16'h0001 == thr_q[gi]; // R1 R7 R9 R12
        cnt_d[gi] = cnt_step(cnt_q[gi], cnt_inc[gi], cnt_hit[gi]);
        if (wr && hit(paddr, 12'(`RPES_OFF_ERR_CNT + 4 * gi)))
          cnt_d[gi] = pwdata[15:0];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // reset symbol run and event vector
  // any other symbol breaks the run; it restarts after firing
  always_comb
  begin
    rst_run_d = rst_run_q;
    if (sym_valid)
    begin
      if (!sym_is_rst)
        rst_run_d = 3'h0;
      else if (rst_run_q == `RPES_RST_SYM_RUN - 3'h1)
        rst_run_d = 3'h0; // R3
      else
        rst_run_d = rst_run_q + 3'h1;
    end
    ev = '0; // R13
    ev[`RPES_BIT_DEG] = cnt_hit[0]; // R1
    ev[`RPES_BIT_OUTQ] = cnt_hit[1]; // R12
    ev[`RPES_BIT_INQ] = cnt_hit[2]; // R7
    ev[`RPES_BIT_RDR] = cnt_hit[3]; // R9
    ev[`RPES_BIT_RST] = sym_valid && sym_is_rst && rst_run_q == `RPES_RST_SYM_RUN - 3'h1; // R3
    ev[`RPES_BIT_MC] = sym_valid && sym_is_mc; // R5
  end

  ////////////////////////////////////////////////////////////////////////////
  // status: write one to clear, set wins
  always_comb
  begin
    stat_d = (stat_q & ~wclr[5:0]) | ev; // R2 R8 R10
    csym_d = csym_q;
    glb_d = glb_q;
    if (hit(paddr, `RPES_OFF_CSYM_STAT))
      csym_d = csym_q & ~wclr[1:0];
    if (hit(paddr, `RPES_OFF_GLB_STAT))
      glb_d = glb_q & ~wclr[1:0];
    if (!hit(paddr, `RPES_OFF_PORT_STAT))
      stat_d = stat_q | ev;
    csym_d[`RPES_BIT_CS_RST] = csym_d[`RPES_BIT_CS_RST] | ev[`RPES_BIT_RST]; // R4
    glb_d[`RPES_BIT_CS_RST] = glb_d[`RPES_BIT_CS_RST] | ev[`RPES_BIT_RST]; // R4
    csym_d[`RPES_BIT_CS_MC] = csym_d[`RPES_BIT_CS_MC] | ev[`RPES_BIT_MC]; // R6
    glb_d[`RPES_BIT_CS_MC] = glb_d[`RPES_BIT_CS_MC] | ev[`RPES_BIT_MC]; // R6
    int_n_d = ~|(stat_d & int_en_q); // R14
    // reset and multicast events never port-write
    pw_d = |(stat_d & pw_en_q & 6'h0F); // R2 R3 R5 R8 R9 R12
    ev_d = ev;
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, answer in the second access cycle
  // reads are captured when the access is taken, so prdata stands with pready
  // writes land at the edge that ends the pready cycle
  always_comb
  begin
    ph_d = ph_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    prdata_d = prdata_q;
    int_en_d = int_en_q;
    pw_en_d = pw_en_q;
    for (int i = 0; i < 4; i++)
      thr_d[i] = thr_q[i];
    mapped = paddr[11:2] <= 10'(`RPES_OFF_RDR_CNT >> 2) && paddr[1:0] == 2'b00;
    case (ph_q)
      RPES_IDLE:
      begin
        if (psel && penable && !pready_q)
        begin
          ph_d = RPES_ACC;
          pready_d = 1'b1;
          pslverr_d = !mapped;
          prdata_d = 32'h0000_0000;
          if (!pwrite && mapped)
          begin
            if (hit(paddr, `RPES_OFF_PORT_STAT)) prdata_d = {26'h0, stat_q};
            if (hit(paddr, `RPES_OFF_CSYM_STAT)) prdata_d = {30'h0, csym_q};
            if (hit(paddr, `RPES_OFF_GLB_STAT)) prdata_d = {30'h0, glb_q};
            if (hit(paddr, `RPES_OFF_INT_EN)) prdata_d = {26'h0, int_en_q};
            if (hit(paddr, `RPES_OFF_PW_EN)) prdata_d = {26'h0, pw_en_q};
            for (int i = 0; i < 4; i++)
            begin
              if (hit(paddr, 12'(`RPES_OFF_DEG_THR + 4 * i))) prdata_d = {16'h0, thr_q[i]};
              if (hit(paddr, 12'(`RPES_OFF_ERR_CNT + 4 * i))) prdata_d = {16'h0, cnt_q[i]};
            end
          end
        end
      end
      RPES_ACC:
      begin
        ph_d = RPES_IDLE;
        if (wr && mapped)
        begin
          if (hit(paddr, `RPES_OFF_INT_EN)) int_en_d = pwdata[5:0];
          if (hit(paddr, `RPES_OFF_PW_EN)) pw_en_d = pwdata[5:0];
          for (int i = 0; i < 4; i++)
            if (hit(paddr, 12'(`RPES_OFF_DEG_THR + 4 * i)))
              thr_d[i] = pwdata[15:0];
        end
      end
      default:
        ph_d = RPES_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 4; i++)
        cnt_q[i] <= '0;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset symbol run register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rst_run_q <= 3'h0;
    end
    else
    begin
      rst_run_q <= rst_run_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status and notification registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stat_q <= '0;
      csym_q <= 2'h0;
      glb_q <= 2'h0;
      int_n_q <= 1'b1;
      pw_q <= 1'b0;
      ev_q <= '0;
    end
    else
    begin
      stat_q <= stat_d;
      csym_q <= csym_d;
      glb_q <= glb_d;
      int_n_q <= int_n_d;
      pw_q <= pw_d;
      ev_q <= ev_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb and configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ph_q <= RPES_IDLE;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      int_en_q <= `RPES_RST_EN;
      pw_en_q <= `RPES_RST_EN;
      for (int i = 0; i < 3; i++)
        thr_q[i] <= `RPES_RST_THR;
      thr_q[3] <= `RPES_RST_RDR_THR; // R11
    end
    else
    begin
      ph_q <= ph_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      int_en_q <= int_en_d;
      pw_en_q <= pw_en_d;
      thr_q <= thr_d;
    end
  end

  // every output straight from a flop
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign int_n = int_n_q;
  assign pw_req = pw_q;
  assign event_pulse = ev_q;

endmodule : rpes_top
`default_nettype wire

// ==== rpes_top_sva.sv ====
// rpes_top_sva.sv: port checks of the event status block.
// assumes: bound to rpes_top by the testbench.
`timescale 1ns/1ps
`default_nettype none
module rpes_top_sva (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, low
  input wire logic psel, // apb
  input wire logic penable, // apb
  input wire logic pwrite, // apb
  input wire logic pready, // apb
  input wire logic err_rate_inc, // event
  input wire logic outq_exceed, // event
  input wire logic inq_exceed, // event
  input wire logic rdr_inc, // event
  input wire logic sym_valid, // symbol
  input wire logic sym_is_mc, // symbol
  input wire logic int_n, // irq, low
  input wire logic pw_req, // port-write
  input wire logic [5:0] event_pulse // strobes
);
  wire [3:0] inc = {rdr_inc, inq_exceed, outq_exceed, err_rate_inc};
  wire wr = pwrite && pready;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  rdy_one_a: assert property (pready |=> !pready) else $error("pready held");
  rdy_wait_a: assert property (psel && penable && !pready |=> pready) else $error("no pready");
  rdy_cause_a: assert property (pready |-> $past(psel && penable)) else $error("stray pready");
  mc_event_a: assert property (sym_valid && sym_is_mc |=> event_pulse[5]) else $error("mc missed");
  rst_cause_a: assert property (event_pulse[4] |-> $past(sym_valid)) else $error("rst stray");
  ev_cause_a: assert property ((event_pulse[3:0] & ~$past(inc)) == 4'h0) else $error("count stray");
  pw_cause_a: assert property ($rose(pw_req) |-> |event_pulse[3:0] || $past(wr) || $past(wr, 2))
    else $error("pw stray");
  int_cause_a: assert property ($fell(int_n) |-> |event_pulse || $past(wr) || $past(wr, 2))
    else $error("irq stray");
  cover property (event_pulse[4]);
  cover property (!int_n && pw_req);
  cover property (pready && !pwrite);
endmodule : rpes_top_sva
`default_nettype wire

// ==== tb.sv ====
// tb.sv: self-checking bench of the port event status block.
// assumes: rpes_link_model drives the event inputs.
`timescale 1ns/1ps
`default_nettype none
`include "rpes_consts.svh"
module tb;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, int_n, pw_req, er;
  logic err_rate_inc, outq_exceed, inq_exceed, rdr_inc, sym_valid, sym_is_rst, sym_is_mc;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0] event_pulse;
  int err_count = 0;
  int checks_done = 0;
  rpes_top u_rpes_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .int_n(int_n),
    .err_rate_inc(err_rate_inc), .outq_exceed(outq_exceed), .inq_exceed(inq_exceed), .rdr_inc(rdr_inc),
    .sym_valid(sym_valid), .sym_is_rst(sym_is_rst), .sym_is_mc(sym_is_mc), .pw_req(pw_req),
    .event_pulse(event_pulse));
  rpes_link_model u_rpes_link_model (.pclk(pclk), .err_rate_inc(err_rate_inc), .outq_exceed(outq_exceed),
    .inq_exceed(inq_exceed), .rdr_inc(rdr_inc), .sym_valid(sym_valid), .sym_is_rst(sym_is_rst),
    .sym_is_mc(sym_is_mc));
  initial forever #2.5 pclk = ~pclk;
  initial #20000 test_done(1);
  ////////////////////////////////
  task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s exp %h seen %h", s, exp, seen);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk);
    while (pready !== 1'b1 && ++n < 40);
    err_count += int'(n == 40);
    {rd, er} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask : apb
  task rdc(input string s, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(s, rd, exp);
  endtask : rdc
  task test_done(input int extra);
    err_count += extra;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done
  ////////////////////////////////
  task t_reset;
    chk("int_n", int_n, 1'b1);
    rdc("rdr_thr", `RPES_OFF_RDR_THR, 32'h0000FFFF);
    rdc("unmapped", 12'h034, 32'h0);
    chk("slverr", er, 1'b1);
    $display("t_reset done");
  endtask : t_reset
  task t_count;
    apb(1'b1, `RPES_OFF_INT_EN, 32'h3F);
    apb(1'b1, `RPES_OFF_PW_EN, 32'h3F);
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b1, `RPES_OFF_DEG_THR + 12'(4 * k), 32'h3);
      u_rpes_link_model.send(k, 2);
      #1 chk("early", event_pulse, 32'h0);
      u_rpes_link_model.send(k, 1);
      #1 chk("pulse", event_pulse, 32'h1 << k);
      chk("int_n", int_n, 1'b0);
      chk("pw_req", pw_req, 1'b1);
      rdc("status", `RPES_OFF_PORT_STAT, 32'h1 << k);
      rdc("count", `RPES_OFF_ERR_CNT + 12'(4 * k), 32'h0);
      apb(1'b1, `RPES_OFF_PORT_STAT, 32'h1 << k);
      #1 chk("int_off", int_n, 1'b1);
      chk("pw_off", pw_req, 1'b0);
    end
    $display("t_count done");
  endtask : t_count
  task t_sym;
    u_rpes_link_model.sym(1'b1, 1'b0, 3);
    u_rpes_link_model.sym(1'b0, 1'b1, 1);
    #1 chk("mc", event_pulse, 32'h20);
    rdc("cs_stat", `RPES_OFF_CSYM_STAT, 32'h1);
    rdc("glb_stat", `RPES_OFF_GLB_STAT, 32'h1);
    u_rpes_link_model.sym(1'b1, 1'b0, 4);
    #1 chk("rst", event_pulse, 32'h10);
    chk("no_pw", pw_req, 1'b0);
    rdc("cs_stat", `RPES_OFF_CSYM_STAT, 32'h3);
    rdc("glb_stat", `RPES_OFF_GLB_STAT, 32'h3);
    rdc("port_stat", `RPES_OFF_PORT_STAT, 32'h30);
    apb(1'b1, `RPES_OFF_INT_EN, 32'h0);
    @(posedge pclk);
    #1 chk("masked", int_n, 1'b1);
    $display("t_sym done");
  endtask : t_sym
  task t_clear;
    apb(1'b1, `RPES_OFF_CSYM_STAT, 32'h1);
    rdc("cs_clr", `RPES_OFF_CSYM_STAT, 32'h2);
    rdc("glb_keep", `RPES_OFF_GLB_STAT, 32'h3);
    apb(1'b1, `RPES_OFF_GLB_STAT, 32'h3);
    rdc("glb_clr", `RPES_OFF_GLB_STAT, 32'h0);
    apb(1'b1, `RPES_OFF_ERR_CNT, 32'h2);
    u_rpes_link_model.send(0, 1);
    #1 chk("preset", event_pulse, 32'h1);
    chk("deg_pw", pw_req, 1'b1);
    chk("deg_masked", int_n, 1'b1);
    rdc("deg_stat", `RPES_OFF_PORT_STAT, 32'h31);
    $display("t_clear done");
  endtask : t_clear
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_count();
    t_sym();
    t_clear();
    test_done(0);
  end
endmodule : tb
bind rpes_top rpes_top_sva u_rpes_top_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .err_rate_inc(err_rate_inc), .outq_exceed(outq_exceed), .int_n(int_n),
  .inq_exceed(inq_exceed), .rdr_inc(rdr_inc), .sym_valid(sym_valid), .sym_is_mc(sym_is_mc),
  .pw_req(pw_req), .event_pulse(event_pulse));
`default_nettype wire
